//--- dv/hssc_host_model.sv
// Host-side model that reaches the controller over its register port
`timescale 1ns/1ps
`default_nettype none
module hssc_host_model (
  input wire logic clk_sys,
  output logic [7:0] reg_addr,
  output logic [31:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [31:0] reg_rdata
);
  // Bus idles with both strobes low from time zero
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  // One-cycle write; carries position loads and stop configuration
  task automatic wr(input logic [7:0] addr, input logic [31:0] data);
    @(posedge clk_sys);
    reg_addr <= addr;
    reg_wdata <= data;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr

  // One-cycle read; data stand only in the following cycle
  task automatic rd(input logic [7:0] addr, output logic [31:0] data);
    @(posedge clk_sys);
    reg_addr <= addr;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    data = reg_rdata;
  endtask : rd
endmodule : hssc_host_model
`default_nettype wire

//--- dv/test_origin_search_stop_control.sv
// Self-checking bench for the origin search and stop control block
`timescale 1ns/1ps
`default_nettype none
module test_origin_search_stop_control;
  logic clk_sys, rst, reg_wr, reg_rd, all_stop_pin, no_sender_stop;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, d;
  logic [1:0] origin_pin, general_input_zero, general_input_one;
  logic [1:0] general_input_two, general_input_three;
  logic [1:0] step_pulse, step_dir, axis_busy, gp_in_zero;
  int n_fail = 0;
  int checks = 0;

  // Short ms timebase keeps slow creep runs within the cycle budget
  hssc_core #(.NAX(2), .MS_CYC(10)) uut (.clk_sys(clk_sys), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .all_stop_pin(all_stop_pin),
    .no_sender_stop(no_sender_stop), .origin_pin(origin_pin),
    .general_input_zero(general_input_zero),
    .general_input_one(general_input_one),
    .general_input_two(general_input_two),
    .general_input_three(general_input_three), .step_pulse(step_pulse),
    .step_dir(step_dir), .axis_busy(axis_busy), .gp_in_zero(gp_in_zero));
  hssc_host_model host (.clk_sys(clk_sys), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata));

  // 250 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : complete_run

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Bounded wait on an axis busy level; running out ends the run
  task automatic wait_busy(input int ax, input logic lvl, input int bound);
    int i;
    for (i = 0; i < bound; i++) begin
      @(posedge clk_sys);
      #1;
      if (axis_busy[ax] === lvl) break;
    end
    chk(32'(axis_busy[ax]), 32'(lvl));
    if (i == bound) complete_run();
  endtask : wait_busy

  task automatic seek(input int ax, input logic [2:0] cmd);
    host.wr(ax ? hssc_pkg::CMD_B_OFS : hssc_pkg::CMD_A_OFS, 32'(cmd));
  endtask : seek

  // Sensors pass a two-flop synchroniser, so settle before commanding
  task automatic settle();
    repeat (4) @(posedge clk_sys);
    #1;
  endtask : settle

  task automatic t_reset_values();
    host.rd(hssc_pkg::POS_A_OFS, d);
    chk(d, 32'h0000_0000);
    host.rd(hssc_pkg::POS_B_OFS, d);
    chk(d, 32'h0000_0000);
    host.rd(hssc_pkg::STOPCFG_OFS, d);
    chk(d, 32'(hssc_pkg::STOPCFG_RESET));
    host.rd(hssc_pkg::CTRL_OFS, d);
    chk(d, 32'(hssc_pkg::CTRL_RESET));
    host.rd(8'h40, d);
    chk(d, 32'h0000_0000);
    $display("reset values done");
  endtask : t_reset_values

  task automatic t_position_load();
    host.wr(hssc_pkg::POS_A_OFS, 32'h0000_0064);
    host.rd(hssc_pkg::POS_A_OFS, d);
    chk(d, 32'h0000_0064);
    $display("position load done");
  endtask : t_position_load

  task automatic t_seek_rise();
    @(posedge clk_sys) origin_pin <= 2'b01;
    settle();
    seek(0, hssc_pkg::CMD_SEEK_RISE);
    settle();
    chk(32'(axis_busy[0]), 32'h0000_0000);
    host.rd(hssc_pkg::STATUS_OFS, d);
    chk(d, 32'h0000_0007);
    @(posedge clk_sys) origin_pin <= 2'b00;
    settle();
    seek(0, hssc_pkg::CMD_SEEK_RISE);
    wait_busy(0, 1'b1, 8);
    chk(32'(step_dir[0]), 32'h0000_0001);
    repeat (20) @(posedge clk_sys);
    origin_pin <= 2'b01;
    wait_busy(0, 1'b0, 8);
    $display("rising seek done");
  endtask : t_seek_rise

  task automatic t_seek_fall();
    seek(0, hssc_pkg::CMD_SEEK_FALL);
    wait_busy(0, 1'b1, 8);
    @(posedge clk_sys) origin_pin <= 2'b00;
    wait_busy(0, 1'b0, 8);
    $display("falling seek done");
  endtask : t_seek_fall

  task automatic t_seek_index();
    logic seen;
    seen = 1'b0;
    @(posedge clk_sys) general_input_zero <= 2'b01;
    settle();
    chk(32'(gp_in_zero[0]), 32'h0000_0001);
    seek(0, hssc_pkg::CMD_SEEK_INDEX);
    settle();
    chk(32'(axis_busy[0]), 32'h0000_0000);
    @(posedge clk_sys) general_input_zero <= 2'b00;
    settle();
    seek(0, hssc_pkg::CMD_SEEK_INDEX);
    wait_busy(0, 1'b1, 8);
    @(posedge clk_sys) general_input_zero <= 2'b11;
    repeat (8) begin
      @(posedge clk_sys);
      #1;
      if (axis_busy[0] && gp_in_zero[0]) seen = 1'b1;
    end
    chk(32'(seen), 32'h0000_0000);
    chk(32'(axis_busy[0]), 32'h0000_0000);
    chk(32'(gp_in_zero), 32'h0000_0003);
    @(posedge clk_sys) general_input_zero <= 2'b00;
    $display("index seek done");
  endtask : t_seek_index

  task automatic t_all_stop();
    seek(0, hssc_pkg::CMD_SEEK_FALL);
    seek(1, hssc_pkg::CMD_SEEK_FALL);
    wait_busy(1, 1'b1, 8);
    chk(32'(axis_busy), 32'h0000_0003);
    @(posedge clk_sys) all_stop_pin <= 1'b1;
    wait_busy(0, 1'b0, 8);
    chk(32'(axis_busy), 32'h0000_0000);
    seek(1, hssc_pkg::CMD_SEEK_FALL);
    settle();
    chk(32'(axis_busy), 32'h0000_0000);
    host.rd(hssc_pkg::STATUS_OFS, d);
    chk(d, 32'h0000_000B);
    @(posedge clk_sys) all_stop_pin <= 1'b0;
    settle();
    $display("all stop done");
  endtask : t_all_stop

  // Stop signal input enabled as immediate type, then asserted
  task automatic t_stop_signal();
    host.wr(hssc_pkg::STOPCFG_OFS, 32'h0000_00F9);
    seek(0, hssc_pkg::CMD_SEEK_FALL);
    wait_busy(0, 1'b1, 8);
    @(posedge clk_sys) general_input_one <= 2'b01;
    wait_busy(0, 1'b0, 8);
    seek(0, hssc_pkg::CMD_SEEK_FALL);
    settle();
    chk(32'(axis_busy[0]), 32'h0000_0000);
    @(posedge clk_sys) general_input_one <= 2'b00;
    host.wr(hssc_pkg::STOPCFG_OFS, 32'(hssc_pkg::STOPCFG_RESET));
    $display("stop signal done");
  endtask : t_stop_signal

  // Flat profile, start inside half lower speed: ends half lower speed past zero
  task automatic t_flat_seek();
    int steps;
    int i;
    steps = 0;
    host.wr(hssc_pkg::SPEED_OFS, 32'h0000_0010);
    host.wr(hssc_pkg::UPPER_OFS, 32'h0000_002F);
    host.wr(hssc_pkg::POS_A_OFS, 32'h0000_0002);
    seek(0, hssc_pkg::CMD_SEEK_FALL);
    wait_busy(0, 1'b1, 8);
    for (i = 0; i < 40000 && axis_busy[0] === 1'b1; i++) begin
      @(posedge clk_sys);
      #1;
      if (step_pulse[0] === 1'b1) steps++;
    end
    chk(32'(axis_busy[0]), 32'h0000_0000);
    if (i == 40000) complete_run();
    chk(32'(steps), 32'h0000_000A);
    host.rd(hssc_pkg::POS_A_OFS, d);
    chk({8'h00, d[23:0]}, 32'h00FF_FFF8);
    $display("flat seek done");
  endtask : t_flat_seek

  // Main sequence: reset for two cycles, then each scenario in turn
  initial begin
    rst = 1'b1;
    all_stop_pin = 1'b0;
    no_sender_stop = 1'b0;
    origin_pin = 2'b00;
    general_input_zero = 2'b00;
    general_input_one = 2'b00;
    general_input_two = 2'b00;
    general_input_three = 2'b00;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset_values();
    t_position_load();
    t_seek_rise();
    t_seek_fall();
    t_seek_index();
    t_all_stop();
    t_stop_signal();
    t_flat_seek();
    complete_run();
  end
endmodule : test_origin_search_stop_control
`default_nettype wire

//--- hw/hssc_core.sv
// Two-axis origin search sequencer with stop functions
//
// Local design decisions: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module hssc_core #(
  parameter int NAX = 2,
  parameter int MS_CYC = hssc_pkg::MS_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic all_stop_pin,
  input wire logic no_sender_stop,
  input wire logic [1:0] origin_pin,
  input wire logic [1:0] general_input_zero,
  input wire logic [1:0] general_input_one,
  input wire logic [1:0] general_input_two,
  input wire logic [1:0] general_input_three,
  output logic [1:0] step_pulse,
  output logic [1:0] step_dir,
  output logic [1:0] axis_busy,
  output logic [1:0] gp_in_zero
);
  localparam int PW = hssc_pkg::POS_W;
  localparam int SW = hssc_pkg::SPEED_W;
  // Step accumulator wraps once per second of clock time, so steps = pps
  localparam int STEP_DIV = MS_CYC * 1000;

  // Two-flop synchronisers on every pin input
  logic [11:0] sync1_reg, sync2_reg;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= {all_stop_pin, no_sender_stop, origin_pin,
                    general_input_zero, general_input_one,
                    general_input_two, general_input_three};
      sync2_reg <= sync1_reg;
    end
  end
  logic all_stop_s, sender_lost_s;
  logic [1:0] origin_s, gi0_s, gi1_s, sens_s;
  assign all_stop_s = sync2_reg[11];
  assign sender_lost_s = sync2_reg[10];
  assign origin_s = sync2_reg[9:8];
  assign gi0_s = sync2_reg[7:6];
  assign gi1_s = sync2_reg[5:4];
  // Either stop sensor of an axis counts; merged only after synchronising
  assign sens_s = sync2_reg[3:2] | sync2_reg[1:0];

  // Shared register file
  logic [SW-1:0] lower_reg, lower_next, upper_reg, upper_next;
  logic [SW-1:0] accel_reg, accel_next;
  logic [7:0] stopcfg_reg, stopcfg_next;
  logic [1:0] ctrl_reg, ctrl_next;
  always_comb begin
    lower_next = lower_reg;
    upper_next = upper_reg;
    accel_next = accel_reg;
    stopcfg_next = stopcfg_reg;
    ctrl_next = ctrl_reg;
    if (reg_wr) begin
      unique case (reg_addr)
        hssc_pkg::SPEED_OFS: lower_next = reg_wdata[SW-1:0];
        hssc_pkg::UPPER_OFS: upper_next = reg_wdata[SW-1:0];
        hssc_pkg::ACCEL_OFS: accel_next = reg_wdata[SW-1:0];
        hssc_pkg::STOPCFG_OFS: stopcfg_next = reg_wdata[7:0];
        hssc_pkg::CTRL_OFS: ctrl_next = reg_wdata[1:0];
        default: ;
      endcase
    end
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      lower_reg <= hssc_pkg::LOWER_RESET;
      upper_reg <= hssc_pkg::UPPER_RESET;
      accel_reg <= hssc_pkg::ACCEL_RESET;
      stopcfg_reg <= hssc_pkg::STOPCFG_RESET;
      ctrl_reg <= hssc_pkg::CTRL_RESET;
    end else begin
      lower_reg <= lower_next;
      upper_reg <= upper_next;
      accel_reg <= accel_next;
      stopcfg_reg <= stopcfg_next;
      ctrl_reg <= ctrl_next;
    end
  end

  // Millisecond timebase drives speed updates; steps come from the per-cycle accumulator
  logic [31:0] ms_cnt_reg, ms_cnt_next;
  logic ms_tick;
  assign ms_tick = (ms_cnt_reg == 32'(MS_CYC - 1));
  always_comb ms_cnt_next = ms_tick ? '0 : ms_cnt_reg + 32'h0000_0001;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) ms_cnt_reg <= '0;
    else ms_cnt_reg <= ms_cnt_next;
  end

  // Flat profile when span is small or the ramp is too short
  logic [SW-1:0] span;
  logic flat_prof;
  assign span = (upper_reg > lower_reg) ? upper_reg - lower_reg : '0;
  assign flat_prof = (span <= hssc_pkg::FLAT_SPAN_MAX) ||
    (accel_reg == '0) ||
    (32'(span) * 32'd1000 <= 32'(accel_reg) * 32'(hssc_pkg::ACC_MIN_MS));

  logic [NAX-1:0] rdy_a, err_a;
  logic [NAX*PW-1:0] pos_a;
  logic [NAX*3-1:0] st_a;
  logic [NAX-1:0] pulse_a, dir_a;
  logic [NAX-1:0] gp_in_zero_d;

  // Per-axis sequencer
  for (genvar ax = 0; ax < NAX; ax++) begin : g_axis
    hssc_pkg::hssc_state_t st_reg, st_next;
    logic signed [PW-1:0] pos_reg, pos_next;
    logic [PW-1:0] remain_reg, remain_next;
    logic [SW-1:0] spd_reg, spd_next;
    logic [31:0] acc_reg, acc_next;
    logic [2:0] kind_reg, kind_next;
    logic dir_reg, dir_next, err_reg, err_next, pulse_reg, pulse_next;
    logic prev_reg, prev_next;
    logic cmd_wr, pos_wr, load_start;
    logic idx_in, trig_in, trig_prev, hit;
    logic stop_imm, stop_dec, reject;
    logic [PW-1:0] mag, half_low, travel, ramp_dist;
    logic [7:0] cmd_ofs, pos_ofs;

    assign cmd_ofs = (ax == 0) ? hssc_pkg::CMD_A_OFS : hssc_pkg::CMD_B_OFS;
    assign pos_ofs = (ax == 0) ? hssc_pkg::POS_A_OFS : hssc_pkg::POS_B_OFS;
    assign cmd_wr = reg_wr && (reg_addr == cmd_ofs);
    assign pos_wr = reg_wr && (reg_addr == pos_ofs);
    // Index sensor only while the index seek runs; otherwise general input
    assign idx_in = (kind_reg == hssc_pkg::CMD_SEEK_INDEX) &&
                    gi0_s[ax];
    assign gp_in_zero_d[ax] = (kind_reg == hssc_pkg::CMD_SEEK_INDEX) ?
                              1'b0 : gi0_s[ax];
    // Pick the sensor watched by the running seek
    assign trig_in = (kind_reg == hssc_pkg::CMD_SEEK_INDEX) ? gi0_s[ax] :
                     origin_s[ax];
    assign trig_prev = prev_reg;
    assign hit = (st_reg != hssc_pkg::HSSC_IDLE) && (
      ((kind_reg == hssc_pkg::CMD_SEEK_RISE) && origin_s[ax] && !trig_prev) ||
      ((kind_reg == hssc_pkg::CMD_SEEK_FALL) && !origin_s[ax] && trig_prev) ||
      (idx_in && !trig_prev));
    // Configurable stops; all-stop always immediate on both axes
    assign stop_imm = all_stop_s || hit ||
      (stopcfg_reg[hssc_pkg::STOP_SIG_EN_BIT] && gi1_s[ax] &&
       !stopcfg_reg[hssc_pkg::STOP_SIG_DECEL_BIT]) ||
      (stopcfg_reg[hssc_pkg::SENDER_EN_BIT] && sender_lost_s &&
       !stopcfg_reg[hssc_pkg::SENDER_DECEL_BIT]) ||
      (stopcfg_reg[hssc_pkg::STOP_SENS_EN_BIT] && sens_s[ax] &&
       !stopcfg_reg[hssc_pkg::STOP_SENS_DECEL_BIT]);
    assign stop_dec =
      (stopcfg_reg[hssc_pkg::STOP_SIG_EN_BIT] && gi1_s[ax]) ||
      (stopcfg_reg[hssc_pkg::SENDER_EN_BIT] && sender_lost_s) ||
      (stopcfg_reg[hssc_pkg::STOP_SENS_EN_BIT] && sens_s[ax]);
    assign reject = all_stop_s || stop_dec;

    // Distance figures; magnitude of position and half lower speed
    assign mag = pos_reg[PW-1] ? PW'(-pos_reg) : PW'(pos_reg);
    assign half_low = PW'(lower_reg >> 1);
    // Same sum either side of zero; a short seek ends half lower speed past zero
    assign travel = mag + half_low;
    assign ramp_dist = PW'(spd_reg - lower_reg);
    assign load_start = cmd_wr && (st_reg == hssc_pkg::HSSC_IDLE) &&
      (reg_wdata[2:0] inside {hssc_pkg::CMD_SEEK_RISE,
       hssc_pkg::CMD_SEEK_FALL, hssc_pkg::CMD_SEEK_INDEX});

    always_comb begin
      st_next = st_reg;
      pos_next = pos_reg;
      remain_next = remain_reg;
      spd_next = spd_reg;
      acc_next = acc_reg;
      kind_next = kind_reg;
      dir_next = dir_reg;
      err_next = err_reg;
      pulse_next = 1'b0;
      prev_next = trig_in;
      if (pos_wr) pos_next = reg_wdata[PW-1:0];
      if (load_start) begin
        if (reject ||
            (reg_wdata[2:0] == hssc_pkg::CMD_SEEK_RISE && origin_s[ax]) ||
            (reg_wdata[2:0] == hssc_pkg::CMD_SEEK_INDEX && gi0_s[ax])) begin
          err_next = 1'b1;
        end else begin
          err_next = 1'b0;
          kind_next = reg_wdata[2:0];
          dir_next = !pos_reg[PW-1] && (pos_reg != '0); // Toward zero
          // Seeks always reduce and correct, so start at lower speed
          remain_next = travel;
          spd_next = lower_reg;
          acc_next = '0;
          prev_next = (reg_wdata[2:0] == hssc_pkg::CMD_SEEK_INDEX) ?
                      gi0_s[ax] : origin_s[ax];
          // Short seeks have no room to ramp, so they creep throughout
          st_next = (flat_prof || mag < half_low) ?
                    hssc_pkg::HSSC_CREEP : hssc_pkg::HSSC_ACCEL;
        end
      end else if (cmd_wr && reg_wdata[2:0] == hssc_pkg::CMD_STOP &&
                   st_reg != hssc_pkg::HSSC_IDLE && !stop_imm) begin
        // An immediate stop outranks a braking request in the same cycle
        st_next = hssc_pkg::HSSC_BRAKE;
      end else if (st_reg != hssc_pkg::HSSC_IDLE) begin
        if (stop_imm) begin
          st_next = hssc_pkg::HSSC_IDLE;
          kind_next = hssc_pkg::CMD_NONE;
        end else if (stop_dec && st_reg != hssc_pkg::HSSC_BRAKE) begin
          // Once braking, keep ramping down while the condition holds
          st_next = hssc_pkg::HSSC_BRAKE;
        end else begin
          // Step generation: speed in pps against a one-second accumulator
          acc_next = acc_reg + 32'(spd_reg);
          if (acc_reg >= 32'(STEP_DIV) && remain_reg != '0) begin
            acc_next = acc_reg + 32'(spd_reg) - 32'(STEP_DIV);
            pulse_next = 1'b1;
            remain_next = remain_reg - PW'(1);
            pos_next = dir_reg ? pos_reg - 1'b1 : pos_reg + 1'b1;
          end
          if (ms_tick) begin
            unique case (st_reg)
              hssc_pkg::HSSC_ACCEL: begin
                spd_next = (spd_reg + accel_reg / 16'd1000 >= upper_reg) ?
                           upper_reg : spd_reg + 16'd1 + accel_reg / 16'd1000;
                if (remain_reg <= ramp_dist + lower_reg)
                  st_next = hssc_pkg::HSSC_DECEL;
                else if (spd_next == upper_reg)
                  st_next = hssc_pkg::HSSC_CRUISE;
              end
              hssc_pkg::HSSC_CRUISE:
                if (remain_reg <= ramp_dist + lower_reg)
                  st_next = hssc_pkg::HSSC_DECEL;
              hssc_pkg::HSSC_DECEL, hssc_pkg::HSSC_BRAKE: begin
                spd_next = (spd_reg <= lower_reg + 16'd1 + accel_reg / 16'd1000)
                           ? lower_reg : spd_reg - 16'd1 - accel_reg / 16'd1000;
                if (spd_next == lower_reg)
                  st_next = (st_reg == hssc_pkg::HSSC_BRAKE) ?
                            hssc_pkg::HSSC_IDLE : hssc_pkg::HSSC_CREEP;
              end
              default: ;
            endcase
          end
          if (remain_reg == '0) st_next = hssc_pkg::HSSC_IDLE;
        end
      end
      // A halted axis forgets its seek, freeing general input zero
      if (st_next == hssc_pkg::HSSC_IDLE) kind_next = hssc_pkg::CMD_NONE;
    end

    always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
        st_reg <= hssc_pkg::HSSC_IDLE;
        pos_reg <= '0;
        remain_reg <= '0;
        spd_reg <= '0;
        acc_reg <= '0;
        kind_reg <= hssc_pkg::CMD_NONE;
        dir_reg <= 1'b0;
        err_reg <= 1'b0;
        pulse_reg <= 1'b0;
        prev_reg <= 1'b0;
      end else begin
        st_reg <= st_next;
        pos_reg <= pos_next;
        remain_reg <= remain_next;
        spd_reg <= spd_next;
        acc_reg <= acc_next;
        kind_reg <= kind_next;
        dir_reg <= dir_next;
        err_reg <= err_next;
        pulse_reg <= pulse_next;
        prev_reg <= prev_next;
      end
    end
    assign rdy_a[ax] = (st_reg == hssc_pkg::HSSC_IDLE);
    assign err_a[ax] = err_reg;
    assign pos_a[ax*PW +: PW] = pos_reg;
    assign st_a[ax*3 +: 3] = st_reg;
    assign pulse_a[ax] = pulse_reg;
    assign dir_a[ax] = dir_reg;

    // Outcomes shared by the guards below: halted, or refused in place
    sequence s_halted;
      st_reg == hssc_pkg::HSSC_IDLE;
    endsequence
    sequence s_refused;
      err_reg && (st_reg == hssc_pkg::HSSC_IDLE);
    endsequence

    // Each seek halts the cycle after its own sensor event
    a_rise_halt: assert property (
      @(posedge clk_sys) disable iff (rst)
      (st_reg != hssc_pkg::HSSC_IDLE && kind_reg == hssc_pkg::CMD_SEEK_RISE
       && origin_s[ax] && !prev_reg) |=> s_halted)
      else $error("rising seek did not halt");
    a_fall_halt: assert property (
      @(posedge clk_sys) disable iff (rst)
      (st_reg != hssc_pkg::HSSC_IDLE && kind_reg == hssc_pkg::CMD_SEEK_FALL
       && !origin_s[ax] && prev_reg) |=> s_halted)
      else $error("falling seek did not halt");
    a_index_halt: assert property (
      @(posedge clk_sys) disable iff (rst)
      (st_reg != hssc_pkg::HSSC_IDLE && kind_reg == hssc_pkg::CMD_SEEK_INDEX
       && gi0_s[ax] && !prev_reg) |=> s_halted)
      else $error("index seek did not halt");
    // All-stop halts a moving axis and refuses new starts
    a_allstop_halt: assert property (
      @(posedge clk_sys) disable iff (rst)
      all_stop_s |=> s_halted)
      else $error("all-stop did not halt axis");
    a_reject_start: assert property (
      @(posedge clk_sys) disable iff (rst)
      (load_start && all_stop_s) |=> s_refused)
      else $error("start accepted under all-stop");
    // Any enabled stop condition, or the rising or index seek's sensor already on, refuses a start
    a_stop_reject: assert property (
      @(posedge clk_sys) disable iff (rst)
      (load_start && stop_dec) |=> s_refused)
      else $error("start accepted under stop condition");
    a_index_refuse: assert property (
      @(posedge clk_sys) disable iff (rst)
      (load_start && reg_wdata[2:0] == hssc_pkg::CMD_SEEK_INDEX
       && gi0_s[ax]) |=> s_refused)
      else $error("index seek started with index sensor on");
    a_rise_refuse: assert property (
      @(posedge clk_sys) disable iff (rst)
      (load_start && reg_wdata[2:0] == hssc_pkg::CMD_SEEK_RISE
       && origin_s[ax]) |=> s_refused)
      else $error("rising seek started with origin sensor on");
  end

  // Read mux, data valid the cycle after the read strobe
  logic [31:0] rdata_next;
  always_comb begin
    rdata_next = '0;
    if (reg_rd) begin
      unique case (reg_addr)
        hssc_pkg::CTRL_OFS: rdata_next = 32'(ctrl_reg);
        hssc_pkg::STATUS_OFS: rdata_next = 32'({st_a, err_a, rdy_a});
        hssc_pkg::SPEED_OFS: rdata_next = 32'(lower_reg);
        hssc_pkg::UPPER_OFS: rdata_next = 32'(upper_reg);
        hssc_pkg::ACCEL_OFS: rdata_next = 32'(accel_reg);
        hssc_pkg::STOPCFG_OFS: rdata_next = 32'(stopcfg_reg);
        hssc_pkg::POS_A_OFS: rdata_next = 32'(pos_a[PW-1:0]);
        hssc_pkg::POS_B_OFS: rdata_next = 32'(pos_a[2*PW-1:PW]);
        default: rdata_next = '0;
      endcase
    end
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reg_rdata <= '0;
      step_pulse <= '0;
      step_dir <= '0;
      axis_busy <= '0;
      gp_in_zero <= '0;
    end else begin
      reg_rdata <= rdata_next;
      step_pulse <= pulse_a;
      step_dir <= dir_a;
      axis_busy <= ~rdy_a;
      gp_in_zero <= gp_in_zero_d;
    end
  end
endmodule : hssc_core
`default_nettype wire

//--- hw/hssc_pkg.sv
// Constants and types for the origin search and stop control block
package hssc_pkg;
  // Register offsets (byte addresses)
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] SPEED_OFS = 8'h08;
  localparam logic [7:0] ACCEL_OFS = 8'h0C;
  localparam logic [7:0] STOPCFG_OFS = 8'h10;
  localparam logic [7:0] POS_A_OFS = 8'h14;
  localparam logic [7:0] POS_B_OFS = 8'h18;
  localparam logic [7:0] CMD_A_OFS = 8'h1C;
  localparam logic [7:0] CMD_B_OFS = 8'h20;
  localparam logic [7:0] UPPER_OFS = 8'h24;

  // Command codes written to a command register
  localparam logic [2:0] CMD_NONE = 3'h0;
  localparam logic [2:0] CMD_SEEK_RISE = 3'h1;
  localparam logic [2:0] CMD_SEEK_FALL = 3'h2;
  localparam logic [2:0] CMD_SEEK_INDEX = 3'h3;
  localparam logic [2:0] CMD_STOP = 3'h4;

  // Stop configuration field positions
  localparam int STOP_SIG_EN_BIT = 0;
  localparam int STOP_SIG_DECEL_BIT = 1;
  localparam int STOP_SENS_EN_BIT = 2;
  localparam int STOP_SENS_DECEL_BIT = 3;
  localparam int LIMIT_EN_BIT = 4;
  localparam int LIMIT_DECEL_BIT = 5;
  localparam int SENDER_EN_BIT = 6;
  localparam int SENDER_DECEL_BIT = 7;
  // Stop configuration reset value
  localparam logic [7:0] STOPCFG_RESET = 8'hF8;
  // Control bits: pattern reduction, auto correction
  localparam int PR_EN_BIT = 0;
  localparam int AC_EN_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h3;

  // Speeds and pattern thresholds
  localparam int SPEED_W = 16;
  localparam int POS_W = 24;
  localparam logic [15:0] FLAT_SPAN_MAX = 16'h001F; // Upper-lower <= 31
  localparam int ACC_MIN_MS = 8; // Ramps this short collapse to flat
  localparam logic [15:0] LOWER_RESET = 16'h01F4;
  localparam logic [15:0] UPPER_RESET = 16'h1194;
  localparam logic [15:0] ACCEL_RESET = 16'h03E8;
  // One tick of the internal ms timebase
  localparam int CLK_MHZ = 250;
  localparam int MS_CYCLES = CLK_MHZ * 1000;

  // Per-axis sequencer states
  typedef enum logic [2:0] {
    HSSC_IDLE, HSSC_ACCEL, HSSC_CRUISE, HSSC_DECEL, HSSC_CREEP, HSSC_BRAKE
  } hssc_state_t;
endpackage : hssc_pkg
